/* File: pkg/ulmc_defs.svh */
// Purpose: offsets, field positions, reset values and tick counts of the line/modem control block
// Assumes: register indices are word indices; byte address is four times the index
// Notes: all figures live here once; the package holds only types and one helper
`ifndef ULMC_DEFS_SVH
`define ULMC_DEFS_SVH

// Register indices (haddr[31:2] compared against these)
`define ULMC_IDX_DATA        30'h0C000000
`define ULMC_IDX_IER         30'h0C000001
`define ULMC_IDX_LFC         30'h0C000003
`define ULMC_IDX_MLC         30'h0C000004
`define ULMC_IDX_STS         30'h0C000005
`define ULMC_IDX_MSR         30'h0C000006

// Reset values
`define ULMC_LFC_RESET       8'h00
`define ULMC_MLC_RESET       8'h00
`define ULMC_BYTE_RESET      8'h00

// Line format control fields
`define ULMC_LFC_BANK        7
`define ULMC_LFC_BREAK       6
`define ULMC_LFC_FIXED       5
`define ULMC_LFC_SENSE       4
`define ULMC_LFC_PEN         3
`define ULMC_LFC_STOP        2

// Modem line control fields
`define ULMC_MLC_LOOP        4
`define ULMC_MLC_AUX2        3
`define ULMC_MLC_AUX1        2
`define ULMC_MLC_RTS         1
`define ULMC_MLC_DTR         0
`define ULMC_MLC_WMASK       8'h1F

// Event status / mask layout
`define ULMC_STS_RXRDY       0
`define ULMC_STS_TXDONE      1
`define ULMC_STS_PERR        2
`define ULMC_STS_FERR        3
`define ULMC_STS_MODEM       4
`define ULMC_STS_WMASK       8'h1F

// Bus
`define ULMC_HSIZE_WORD      3'h2

// Oversample tick counts (16 ticks per bit)
`define ULMC_TICK_LAST_BIT   6'h0F
`define ULMC_TICK_LAST_HALF  6'h07
`define ULMC_TICK_LAST_1P5   6'h17
`define ULMC_TICK_LAST_2     6'h1F

`endif

/* File: pkg/ulmc_pkg.sv */
// Purpose: shared types and the parity helper of the line/modem control block
// Assumes: constants come from ulmc_defs.svh
// Notes: parity helper is shared by transmitter and receiver so both agree
package ulmc_pkg;

    typedef logic [31:0] ulmc_word_t;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulmc_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulmc_rx_state_t;

    // Format bundle: {fixed, sense, pen, stop, len[1:0]}
    typedef logic [5:0] ulmc_fmt_t;

    // Parity bit for a character; fixed parity gives 0 for even, 1 for odd
    function automatic logic ulmc_parity(input logic [7:0] d, input ulmc_fmt_t f);
        logic [7:0] m;
        m = 8'hFF >> (2'h3 - f[1:0]);
        if (f[5])
            return ~f[4];
        return f[4] ? ^(d & m) : ~^(d & m);
    endfunction

endpackage

/* File: src/ulmc_tx.sv */
// Purpose: transmit shift engine with start, data, parity and stop phases
// Assumes: tick_i is a one-cycle pulse at sixteen times the bit rate
// Notes: format is latched at start, so register writes mid-frame do not tear a character
`timescale 1ns/1ps
`include "ulmc_defs.svh"
module ulmc_tx (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             start_i,
    input  wire logic [7:0]       data_i,
    input  wire ulmc_pkg::ulmc_fmt_t fmt_i,
    output logic                  line_o,
    output logic                  busy_o,
    output logic                  done_o
);
    import ulmc_pkg::*;

    typedef struct packed {
        ulmc_tx_state_t state;
        logic [5:0]     tick;
        logic [2:0]     idx;
        logic [7:0]     shreg;
        ulmc_fmt_t      fmt;
        logic           par;
        logic           line;
        logic           busy;
        logic           done;
    } ulmc_tx_t;

    ulmc_tx_t s_r, s_nxt;
    logic     last_data;
    logic [5:0] stop_last;

    assign line_o = s_r.line;
    assign busy_o = s_r.busy;
    assign done_o = s_r.done;

    // Data length and stop length from the latched format
    assign last_data = (s_r.idx == {1'b1, s_r.fmt[1:0]});
    assign stop_last = !s_r.fmt[2] ? `ULMC_TICK_LAST_BIT :
                       (s_r.fmt[1:0] == 2'h0) ? `ULMC_TICK_LAST_1P5 : `ULMC_TICK_LAST_2;

    // Frame sequencer
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.state)
            TX_IDLE: begin
                s_nxt.line = 1'b1;
                if (start_i) begin
                    s_nxt.shreg = data_i;
                    s_nxt.fmt   = fmt_i;
                    s_nxt.par   = ulmc_parity(data_i, fmt_i);
                    s_nxt.state = TX_START;
                    s_nxt.tick  = 6'h00;
                    s_nxt.line  = 1'b0;
                    s_nxt.busy  = 1'b1;
                end
            end
            TX_START: begin
                if (tick_i) begin
                    s_nxt.tick = s_r.tick + 6'h01;
                    if (s_r.tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.tick  = 6'h00;
                        s_nxt.idx   = 3'h0;
                        s_nxt.state = TX_DATA;
                        s_nxt.line  = s_r.shreg[0];
                    end
                end
            end
            TX_DATA: begin
                if (tick_i) begin
                    s_nxt.tick = s_r.tick + 6'h01;
                    if (s_r.tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.tick  = 6'h00;
                        s_nxt.shreg = s_r.shreg >> 1;
                        s_nxt.idx   = s_r.idx + 3'h1;
                        s_nxt.line  = s_r.shreg[1];
                        if (last_data) begin
                            // Parity only when enabled; fixed bit alone does nothing
                            s_nxt.state = s_r.fmt[3] ? TX_PAR : TX_STOP;
                            s_nxt.line  = s_r.fmt[3] ? s_r.par : 1'b1;
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tick_i) begin
                    s_nxt.tick = s_r.tick + 6'h01;
                    if (s_r.tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.tick  = 6'h00;
                        s_nxt.state = TX_STOP;
                        s_nxt.line  = 1'b1;
                    end
                end
            end
            TX_STOP: begin
                if (tick_i) begin
                    s_nxt.tick = s_r.tick + 6'h01;
                    if (s_r.tick == stop_last) begin
                        s_nxt.state = TX_IDLE;
                        s_nxt.busy  = 1'b0;
                        s_nxt.done  = 1'b1;
                    end
                end
            end
            default: s_nxt.state = TX_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r      <= '0;
            s_r.line <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_char_len;
        s_r.state == TX_DATA && tick_i && s_r.tick == `ULMC_TICK_LAST_BIT && s_r.idx < {1'b1, s_r.fmt[1:0]}
            |=> s_r.state == TX_DATA;
    endproperty
    a_char_len: assert property (p_char_len) else $error("data phase ended early");

    property p_stop_1p5;
        s_r.state == TX_STOP && s_r.fmt[2] && s_r.fmt[1:0] == 2'h0 && tick_i && s_r.tick < 6'h17
            |=> s_r.state == TX_STOP && s_r.line;
    endproperty
    a_stop_1p5: assert property (p_stop_1p5) else $error("short stop time for 5-bit char");

    property p_fixed_par;
        s_r.state == TX_PAR && s_r.fmt[5] |-> s_r.line == ~s_r.fmt[4];
    endproperty
    a_fixed_par: assert property (p_fixed_par) else $error("fixed parity level wrong");
endmodule

/* File: src/ulmc_top.sv */
// Purpose: line format, break, bank select, modem control and local loopback of a serial port
// Assumes: baud_tick16_i is a one-cycle pulse at sixteen times the bit rate; pins synchronous
// Notes: AHB-Lite slave, zero wait states; reads sample register state in the address phase
`timescale 1ns/1ps
`include "ulmc_defs.svh"
// Notes on behaviour
// - Length code selects five to eight bits
// - Stop select gives 1, 1.5 or 2
// - Parity enable adds/checks bit; sense picks even
// - Fixed parity acts only with parity enabled
// - Break bit forces transmit output to 0 outside loopback
// - Bank bit routes low offsets to divisor
// - Modem control bits 7..5 read zero
// - Low control bits drive outputs low when set
// - Aux outputs act only in loopback
// - Modem bit 4 enables loopback
// - Loopback holds transmit pin high, ignores receive
// - Loopback feeds transmit shifter into receiver
// - Loopback replaces status inputs with control outputs
// - Loopback drives control pins inactive high
// - Loopback modem events come from control bits
// - Receiver flags parity error on mismatch
module ulmc_top (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic                 hsel_i,
    input  wire ulmc_pkg::ulmc_word_t haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic                 hready_i,
    input  wire ulmc_pkg::ulmc_word_t hwdata_i,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    output ulmc_pkg::ulmc_word_t      hrdata_o,
    input  wire logic                 baud_tick16_i,
    input  wire logic                 serial_rx_pin_i,
    output logic                      serial_tx_pin_o,
    output logic                      terminal_ready_n_o,
    output logic                      request_to_send_n_o,
    input  wire logic                 set_ready_n_i,
    input  wire logic                 clear_to_send_n_i,
    input  wire logic                 carrier_detect_n_i,
    input  wire logic                 ring_indicator_n_i,
    output logic                      irq_o
);
    import ulmc_pkg::*;

    typedef struct packed {
        logic           ap_valid;
        logic           ap_write;
        logic [29:0]    ap_idx;
        logic [7:0]     lfc;
        logic [7:0]     mlc;
        logic [7:0]     ier;
        logic [7:0]     dll;
        logic [7:0]     dlm;
        logic [7:0]     rxbuf;
        logic [7:0]     sts;
        logic [3:0]     msr_prev;
        ulmc_rx_state_t rx_state;
        logic [5:0]     rx_tick;
        logic [2:0]     rx_idx;
        logic [7:0]     rx_shreg;
        logic           rx_par;
        ulmc_word_t     hrdata;
        logic           hreadyout;
        logic           tx_pin;
        logic           dtr_n;
        logic           rts_n;
        logic           irq;
    } ulmc_top_t;

    ulmc_top_t  s_r, s_nxt;
    logic       loop;
    logic       tx_line;
    logic       tx_busy;
    logic       tx_done;
    logic       tx_start;
    logic       wr_dp;
    logic       rd_ap;
    logic       rx_in;
    logic [3:0] msr_eff;
    logic [7:0] rx_char;
    logic       rx_stop_hit;
    ulmc_fmt_t  fmt;

    assign hreadyout_o         = s_r.hreadyout;
    assign hresp_o             = 1'b0;
    assign hrdata_o            = s_r.hrdata;
    assign serial_tx_pin_o     = s_r.tx_pin;
    assign terminal_ready_n_o  = s_r.dtr_n;
    assign request_to_send_n_o = s_r.rts_n;
    assign irq_o               = s_r.irq;

    // Loopback switch and format bundle for both shifters
    assign loop = s_r.mlc[`ULMC_MLC_LOOP];
    assign fmt  = {s_r.lfc[`ULMC_LFC_FIXED], s_r.lfc[`ULMC_LFC_SENSE], s_r.lfc[`ULMC_LFC_PEN],
                   s_r.lfc[`ULMC_LFC_STOP], s_r.lfc[1:0]};

    // Bus phase decode; non-word transfers are ignored
    assign rd_ap    = hsel_i && htrans_i[1] && hready_i && !hwrite_i && hsize_i == `ULMC_HSIZE_WORD;
    assign wr_dp    = s_r.ap_valid && s_r.ap_write;
    assign tx_start = wr_dp && s_r.ap_idx == `ULMC_IDX_DATA && !s_r.lfc[`ULMC_LFC_BANK] && !tx_busy;

    // Receiver input: shifter output in loopback, pin otherwise
    assign rx_in = loop ? tx_line : serial_rx_pin_i;

    // Effective status inputs {carrier, ring, cts, dsr}, active high
    assign msr_eff = loop ? {s_r.mlc[`ULMC_MLC_AUX2], s_r.mlc[`ULMC_MLC_AUX1],
                             s_r.mlc[`ULMC_MLC_RTS], s_r.mlc[`ULMC_MLC_DTR]}
                          : {~carrier_detect_n_i, ~ring_indicator_n_i,
                             ~clear_to_send_n_i, ~set_ready_n_i};

    // Received character right-aligned for short lengths
    assign rx_char     = s_r.rx_shreg >> (2'h3 - s_r.lfc[1:0]);
    assign rx_stop_hit = s_r.rx_state == RX_STOP && baud_tick16_i && s_r.rx_tick == `ULMC_TICK_LAST_BIT;

    ulmc_tx u_tx (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (baud_tick16_i),
        .start_i   (tx_start),
        .data_i    (hwdata_i[7:0]),
        .fmt_i     (fmt),
        .line_o    (tx_line),
        .busy_o    (tx_busy),
        .done_o    (tx_done)
    );

    // Registers, receiver, event status and pins in one next-state block
    always_comb begin
        logic [7:0] set_ev;
        logic [7:0] clr_ev;
        set_ev = 8'h00;
        clr_ev = 8'h00;
        s_nxt  = s_r;

        // Address phase capture; hreadyout never drops
        s_nxt.hreadyout = 1'b1;
        s_nxt.ap_valid  = hsel_i && htrans_i[1] && hready_i && hsize_i == `ULMC_HSIZE_WORD;
        s_nxt.ap_write  = hwrite_i;
        s_nxt.ap_idx    = haddr_i[31:2];

        // Read data is sampled in the address phase so it stands in the data phase
        if (rd_ap) begin
            case (haddr_i[31:2])
                `ULMC_IDX_DATA: s_nxt.hrdata = {24'h000000,
                                   s_r.lfc[`ULMC_LFC_BANK] ? s_r.dll : s_r.rxbuf};
                `ULMC_IDX_IER:  s_nxt.hrdata = {24'h000000,
                                   s_r.lfc[`ULMC_LFC_BANK] ? s_r.dlm : s_r.ier};
                `ULMC_IDX_LFC:  s_nxt.hrdata = {24'h000000, s_r.lfc};
                `ULMC_IDX_MLC:  s_nxt.hrdata = {27'h0000000, s_r.mlc[4:0]};
                `ULMC_IDX_STS:  s_nxt.hrdata = {24'h000000, s_r.sts};
                `ULMC_IDX_MSR:  s_nxt.hrdata = {26'h0000000, tx_busy, s_r.rx_state != RX_IDLE,
                                                s_r.msr_prev};
                default:        s_nxt.hrdata = 32'h00000000;
            endcase
        end

        // Data phase writes
        if (wr_dp) begin
            case (s_r.ap_idx)
                `ULMC_IDX_DATA: if (s_r.lfc[`ULMC_LFC_BANK]) s_nxt.dll = hwdata_i[7:0];
                `ULMC_IDX_IER:  begin
                    if (s_r.lfc[`ULMC_LFC_BANK])
                        s_nxt.dlm = hwdata_i[7:0];
                    else
                        s_nxt.ier = hwdata_i[7:0] & `ULMC_STS_WMASK;
                end
                `ULMC_IDX_LFC:  s_nxt.lfc = hwdata_i[7:0];
                `ULMC_IDX_MLC:  s_nxt.mlc = hwdata_i[7:0] & `ULMC_MLC_WMASK;
                `ULMC_IDX_STS:  clr_ev    = hwdata_i[7:0] & `ULMC_STS_WMASK;
                default:        s_nxt.lfc = s_r.lfc;
            endcase
        end

        // Receiver: start detect, mid-bit sampling, parity and stop check
        if (baud_tick16_i) begin
            s_nxt.rx_tick = s_r.rx_tick + 6'h01;
            case (s_r.rx_state)
                RX_IDLE: begin
                    s_nxt.rx_tick = 6'h00;
                    if (!rx_in)
                        s_nxt.rx_state = RX_START;
                end
                RX_START: begin
                    // A glitch shorter than half a bit is dropped
                    if (s_r.rx_tick == `ULMC_TICK_LAST_HALF) begin
                        s_nxt.rx_tick  = 6'h00;
                        s_nxt.rx_idx   = 3'h0;
                        s_nxt.rx_state = rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (s_r.rx_tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.rx_tick  = 6'h00;
                        s_nxt.rx_shreg = {rx_in, s_r.rx_shreg[7:1]};
                        s_nxt.rx_idx   = s_r.rx_idx + 3'h1;
                        if (s_r.rx_idx == {1'b1, s_r.lfc[1:0]})
                            s_nxt.rx_state = s_r.lfc[`ULMC_LFC_PEN] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (s_r.rx_tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.rx_tick  = 6'h00;
                        s_nxt.rx_par   = rx_in;
                        s_nxt.rx_state = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is checked; extra stop time is idle line
                    if (s_r.rx_tick == `ULMC_TICK_LAST_BIT) begin
                        s_nxt.rx_state = RX_IDLE;
                        s_nxt.rxbuf    = rx_char;
                    end
                end
                default: s_nxt.rx_state = RX_IDLE;
            endcase
        end

        // Event sources
        if (rx_stop_hit) begin
            set_ev[`ULMC_STS_RXRDY] = 1'b1;
            set_ev[`ULMC_STS_FERR]  = !rx_in;
            set_ev[`ULMC_STS_PERR]  = s_r.lfc[`ULMC_LFC_PEN] &&
                                      s_r.rx_par != ulmc_parity(rx_char, fmt);
        end
        set_ev[`ULMC_STS_TXDONE] = tx_done;
        set_ev[`ULMC_STS_MODEM]  = msr_eff != s_r.msr_prev;
        s_nxt.msr_prev           = msr_eff;

        // Write-one-to-clear; a same-cycle event wins over the clear
        s_nxt.sts = (s_r.sts & ~clr_ev) | set_ev;
        s_nxt.irq = |(s_r.sts & s_r.ier);

        // Pins: loopback parks everything at mark / inactive
        s_nxt.tx_pin = loop ? 1'b1 : (s_r.lfc[`ULMC_LFC_BREAK] ? 1'b0 : tx_line);
        s_nxt.dtr_n  = loop ? 1'b1 : ~s_r.mlc[`ULMC_MLC_DTR];
        s_nxt.rts_n  = loop ? 1'b1 : ~s_r.mlc[`ULMC_MLC_RTS];
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_r        <= '0;
            s_r.lfc    <= `ULMC_LFC_RESET;
            s_r.mlc    <= `ULMC_MLC_RESET;
            s_r.tx_pin <= 1'b1;
            s_r.dtr_n  <= 1'b1;
            s_r.rts_n  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_break;
        s_r.lfc[`ULMC_LFC_BREAK] && !loop |=> !serial_tx_pin_o;
    endproperty
    a_break: assert property (p_break) else $error("break did not force space");

    property p_loop_tx;
        loop |=> serial_tx_pin_o;
    endproperty
    a_loop_tx: assert property (p_loop_tx) else $error("tx pin not marking in loopback");

    property p_loop_pins;
        loop |=> terminal_ready_n_o && request_to_send_n_o;
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("control pins active in loopback");

    property p_ctl_level;
        !loop |=> terminal_ready_n_o == !$past(s_r.mlc[0]) && request_to_send_n_o == !$past(s_r.mlc[1]);
    endproperty
    a_ctl_level: assert property (p_ctl_level) else $error("control pin level wrong");

    property p_mlc_rsvd;
        rd_ap && haddr_i[31:2] == `ULMC_IDX_MLC |=> hrdata_o[7:5] == 3'h0;
    endproperty
    a_mlc_rsvd: assert property (p_mlc_rsvd) else $error("reserved modem bits not zero");

    property p_bank_dll;
        wr_dp && s_r.ap_idx == `ULMC_IDX_DATA && s_r.lfc[`ULMC_LFC_BANK] |=> s_r.dll == $past(hwdata_i[7:0]) && !$past(tx_start);
    endproperty
    a_bank_dll: assert property (p_bank_dll) else $error("bank select not honoured");

    property p_loop_pair;
        loop && $past(loop) |-> s_r.msr_prev == $past(s_r.mlc[3:0]);
    endproperty
    a_loop_pair: assert property (p_loop_pair) else $error("loopback status pairing wrong");

    sequence s_loop_ctl_change;
        loop && $past(loop) && s_r.mlc[3:0] != $past(s_r.mlc[3:0]);
    endsequence
    property p_loop_event;
        s_loop_ctl_change |=> s_r.sts[`ULMC_STS_MODEM] ##1 (irq_o || !s_r.ier[`ULMC_STS_MODEM]);
    endproperty
    a_loop_event: assert property (p_loop_event) else $error("loopback modem event lost");

    property p_loop_rx;
        loop && s_r.rx_state == RX_IDLE && !tx_line && baud_tick16_i |=> s_r.rx_state == RX_START;
    endproperty
    a_loop_rx: assert property (p_loop_rx) else $error("loopback start not seen by receiver");

    property p_perr;
        rx_stop_hit && s_r.lfc[`ULMC_LFC_PEN] && s_r.rx_par != ulmc_parity(rx_char, fmt) |=> s_r.sts[`ULMC_STS_PERR];
    endproperty
    a_perr: assert property (p_perr) else $error("parity error not flagged");
endmodule

/* File: tb/ulmc_modem.sv */
// Purpose: modem model on the serial and handshake pins
// Assumes: status lines active low; line idles at mark
// Notes: echoes transmit back as a remote loop
`timescale 1ns/1ps
module ulmc_modem (
    input  wire logic       tx_i,
    input  wire logic [3:0] sts_i,
    output logic            rx_o,
    output logic [3:0]      sts_n_o
);
    // Echo keeps rx at mark while tx idles
    assign rx_o    = tx_i;
    // Order {carrier, ring, cts, dsr}
    assign sts_n_o = ~sts_i;
endmodule

/* File: tb/test_uart_line_modem_control_loopback.sv */
// Purpose: bench for format, break, bank, modem control, loopback
// Assumes: zero wait AHB slave, one byte per word
// Notes: serial traffic runs in loopback only
`timescale 1ns/1ps
module test_uart_line_modem_control_loopback;
    import ulmc_pkg::*;
    localparam ulmc_word_t DAT = 32'h30000000, IER = 32'h30000004;
    localparam ulmc_word_t LFC = 32'h3000000C, MLC = 32'h30000010;
    localparam ulmc_word_t STS = 32'h30000014, MSR = 32'h30000018;
    logic       clk_sys_i = 0, rst_i = 1, tick = 0, hsel = 0, hwrite = 0;
    logic       hrdy, hresp, tx, dtr_n, rts_n, irq, rx, txl;
    logic [1:0] htrans = 0;
    logic [3:0] sts = 4'hA, sts_n;
    ulmc_word_t haddr = 0, hwdata = 0, hrdata, q;
    int         bad_count = 0, n_tests = 0;
    ulmc_top ulmc_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .baud_tick16_i(tick),
        .serial_rx_pin_i(rx), .serial_tx_pin_o(tx), .terminal_ready_n_o(dtr_n),
        .request_to_send_n_o(rts_n), .set_ready_n_i(sts_n[0]), .clear_to_send_n_i(sts_n[1]),
        .ring_indicator_n_i(sts_n[2]), .carrier_detect_n_i(sts_n[3]), .irq_o(irq));
    ulmc_modem ulmc_modem_i (.tx_i(tx), .sts_i(sts), .rx_o(rx), .sts_n_o(sts_n));
    // Clock and a tick every other cycle
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) tick <= ~tick;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One single transfer; q takes read data at the data phase end
    task automatic bus(input logic w, input ulmc_word_t a, input ulmc_word_t d);
        @(posedge clk_sys_i);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd(input string nm, input ulmc_word_t a, input ulmc_word_t e);
        bus(0, a, 0);
        chk(nm, q, e);
        chk("hresp", hresp, 1'b0);
    endtask
    task automatic t_modem;
        bus(1, MLC, 32'hF5);
        rd("mlc", MLC, 32'h15);
        chk("pins_loop", {tx, dtr_n, rts_n}, 3'h7);
        bus(0, MSR, 0);
        chk("msr_loop", q & 32'hF, 32'h5);
        bus(1, MLC, 32'h03);
        // Pin flops follow the register one edge after the write lands
        repeat (2) @(posedge clk_sys_i);
        chk("pins_on", {dtr_n, rts_n}, 2'h0);
        bus(1, MLC, 32'h0C);
        bus(0, MSR, 0);
        chk("msr_pins", q & 32'hF, 32'hA);
        $display("modem test done");
    endtask
    task automatic t_break;
        bus(1, LFC, 32'h43);
        repeat (3) @(posedge clk_sys_i);
        chk("break", tx, 1'b0);
        bus(1, LFC, 32'h83);
        repeat (3) @(posedge clk_sys_i);
        chk("unbreak", tx, 1'b1);
        bus(1, DAT, 32'h5A);
        rd("divisor", DAT, 32'h5A);
        chk("no_tx", tx, 1'b1);
        $display("break and bank test done");
    endtask
    // Loopback character: transmit pin stays at mark, clean reception, irq
    task automatic t_loop(input logic [7:0] f, input logic [7:0] d, input logic [7:0] e);
        txl = 0;
        bus(1, LFC, f);
        bus(1, DAT, d);
        // Poll for transmit done; receive finishes mid stop bit, earlier
        q = 0;
        for (int i = 0; i < 300 && q[1] !== 1'b1; i++) begin
            bus(0, STS, 0);
            txl |= !tx;
        end
        chk("sts", q & 32'hF, 32'h3);
        chk("tx_mark", txl, 1'b0);
        chk("irq_set", irq, 1'b1);
        rd("rxchar", DAT, e);
        bus(1, STS, 32'h1F);
        rd("sts_clr", STS, 0);
        chk("irq_clr", irq, 1'b0);
        $display("loopback format %h done", f);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 0;
        rd("lfc_rst", LFC, 0);
        rd("mlc_rst", MLC, 0);
        rd("unmapped", 32'h30000020, 0);
        t_modem();
        t_break();
        // Bank off first, else the mask write lands in the divisor
        bus(1, LFC, 32'h03);
        bus(1, MLC, 32'h10);
        bus(1, IER, 32'h01);
        t_loop(8'h03, 8'hA5, 8'hA5);
        t_loop(8'h04, 8'hFF, 8'h1F);
        t_loop(8'h1E, 8'hC3, 8'h43);
        t_loop(8'h39, 8'h2D, 8'h2D);
        t_loop(8'h2B, 8'h96, 8'h96);
        final_report();
    end
    // Watchdog well beyond five frames
    initial begin
        #(25 * 60000);
        bad_count++;
        final_report();
    end
endmodule
